// ---- rtl/rpss_pkg.sv ----
// Package for the reset pin-state sequencer: phase codes, strap codes, pin levels, timing.
// Assumes a single 100 MHz clock and that every user of these names imports the package.
package rpss_pkg;

  // Clock period in picoseconds, used to turn times into cycle counts.
  localparam int unsigned CLK_PERIOD_PS = 10000;

  // Least time that output reset is held after input reset releases, in nanoseconds.
  localparam int unsigned OUT_RST_HOLD_NS = 1000;
  // Least time rounds up to whole cycles, never below one.
  localparam int unsigned OUT_RST_HOLD_CYC_RAW =
    (OUT_RST_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned OUT_RST_HOLD_CYC =
    (OUT_RST_HOLD_CYC_RAW < 1) ? 1 : OUT_RST_HOLD_CYC_RAW;

  // Number of memory initialisation write cycles issued after release.
  localparam int unsigned MEM_INIT_WRITES = 8;

  // Address of the first code prefetch, top of the 24-bit space.
  localparam logic [23:0] BOOT_PREFETCH_ADDR = 24'hfffff0;
  // System address held on the ISA/PCMCIA bus during the output reset hold, after input reset releases.
  localparam logic [19:0] SA_HOLD_ADDR       = 20'hfff03;
  // Address shown while input reset is asserted; the low byte has no meaning.
  localparam logic [19:0] SA_RESET_ADDR      = 20'hfff00;

  // Strap codes for the muxed external bus.
  localparam logic [1:0] STRAP_ISA    = 2'h0;
  localparam logic [1:0] STRAP_PCMCIA = 2'h1;
  localparam logic [1:0] STRAP_LOCAL  = 2'h2;

  // Reset phases, one-hot.
  typedef enum logic [3:0] {
    RPSS_IN_RST   = 4'h1,
    RPSS_OUT_HOLD = 4'h2,
    RPSS_MEM_INIT = 4'h4,
    RPSS_RUN      = 4'h8
  } rpss_phase_t;

  // Pin levels that the sequencer owns, driven as one group.
  typedef struct packed {
    logic        isa_mem_read_n;
    logic        isa_mem_write_n;
    logic        isa_io_read_n;
    logic        isa_io_write_n;
    logic [19:0] system_address;
    logic        ide_primary_read_strobe_n;
    logic        ide_primary_write_strobe_n;
    logic        ide_secondary_read_strobe_n;
    logic        ide_secondary_write_strobe_n;
    logic        flash_bank0_select_n;
    logic        flash_bank1_select_n;
    logic        flash_bank0_low_select_n;
    logic        flash_bank0_high_select_n;
    logic        flash_bank1_low_select_n;
    logic        flash_bank1_high_select_n;
    logic        card_enable1_n;
    logic        card_enable2_n;
    logic        card_5v_supply_enable;
    logic        card_3v_supply_enable;
    logic        panel_data_enable;
    logic        panel_logic_supply_enable;
    logic        panel_backlight_supply_enable;
    logic        backlight_pulse_width_out;
  } rpss_pins_t;

  // Pin levels loaded during input reset: strobes and selects idle high, panel off.
  localparam rpss_pins_t PINS_RESET = '{
    isa_mem_read_n: 1'b1, isa_mem_write_n: 1'b1, isa_io_read_n: 1'b1, isa_io_write_n: 1'b1,
    system_address: SA_RESET_ADDR,
    ide_primary_read_strobe_n: 1'b1, ide_primary_write_strobe_n: 1'b1,
    ide_secondary_read_strobe_n: 1'b1, ide_secondary_write_strobe_n: 1'b1,
    flash_bank0_select_n: 1'b1, flash_bank1_select_n: 1'b1,
    flash_bank0_low_select_n: 1'b1, flash_bank0_high_select_n: 1'b1,
    flash_bank1_low_select_n: 1'b1, flash_bank1_high_select_n: 1'b1,
    card_enable1_n: 1'b1, card_enable2_n: 1'b1,
    card_5v_supply_enable: 1'b1, card_3v_supply_enable: 1'b1,
    panel_data_enable: 1'b0, panel_logic_supply_enable: 1'b0,
    panel_backlight_supply_enable: 1'b0, backlight_pulse_width_out: 1'b0
  };

  // Prefetch request handed to the bus units at release.
  typedef struct packed {
    logic        start;
    logic        on_pci;
    logic        on_isa;
    logic        on_local;
    logic [23:0] addr;
  } rpss_prefetch_t;

endpackage

// ---- rtl/rpss_sequencer.sv ----
// Reset pin-state sequencer: holds the external pins at defined levels through the reset phases,
// then launches the first boot prefetch and the memory initialisation writes.
// Assumes inputs synchronous to clk_i and bus units that take the one-cycle prefetch pulse.
`timescale 1ns/1ps

// What this block does
// - Non-local strap prefetches first on PCI.
// - First prefetch starts at address 0xFFFFF0.
// - ISA/PCMCIA: address 0xFFF03 during hold, then prefetch.
// - ISA command strobes held high during hold.
// - IDE read/write strobes high in input reset.
// - All flash selects high in input reset.
// - Card enables and supply enables high.
// - Panel enables and backlight PWM low.
module rpss_sequencer #(
  parameter int unsigned HOLD_CYCLES = rpss_pkg::OUT_RST_HOLD_CYC,
  parameter int unsigned INIT_WRITES = rpss_pkg::MEM_INIT_WRITES
) (
  // Clock and block reset.
  input  wire logic                     clk_i,
  input  wire logic                     resetn_i,
  // Board reset in and strap.
  input  wire logic                     system_reset_input_n_i,
  input  wire logic [1:0]               strap_mode_i,
  // Sequenced reset out and pin group.
  output logic                          system_reset_output_n_o,
  output rpss_pkg::rpss_pins_t          pins_o,
  // Boot prefetch launch and memory status.
  output rpss_pkg::rpss_prefetch_t      prefetch_o,
  output logic                          mem_init_write_o,
  output logic                          mem_ready_o,
  output logic [1:0]                    strap_latched_o
);
  import rpss_pkg::*;

  localparam int CW = 16;

  rpss_phase_t     phase_r,  phase_nxt;
  logic [CW-1:0]   count_r,  count_nxt;
  logic [1:0]      strap_r,  strap_nxt;
  logic            orst_n_r, orst_n_nxt;
  rpss_pins_t      pins_r,   pins_nxt;
  rpss_prefetch_t  pf_r,     pf_nxt;
  logic            wr_r,     wr_nxt;
  logic            rdy_r,    rdy_nxt;

  // True when the strap selects a bus that carries the ISA address lines.
  function automatic logic isa_like(input logic [1:0] m);
    isa_like = (m == STRAP_ISA) || (m == STRAP_PCMCIA);
  endfunction

  // Next-state logic. The strap is caught while input reset is low, so it is stable
  // at the release and any later wiggle on the strap pins cannot change the boot path.
  always_comb begin
    phase_nxt  = phase_r;
    count_nxt  = count_r;
    strap_nxt  = strap_r;
    orst_n_nxt = orst_n_r;
    pins_nxt   = pins_r;
    pf_nxt     = pf_r;
    pf_nxt.start = 1'b0;
    wr_nxt     = wr_r;
    rdy_nxt    = rdy_r;
    if (!system_reset_input_n_i) begin
      phase_nxt  = RPSS_IN_RST;
      count_nxt  = '0;
      strap_nxt  = strap_mode_i;
      orst_n_nxt = 1'b0;
      pins_nxt   = PINS_RESET;
      pf_nxt     = '0;
      wr_nxt     = 1'b0;
      rdy_nxt    = 1'b0;
    end else begin
      case (phase_r)
        RPSS_IN_RST: begin
          // First boundary: only the ISA address and strobes change.
          phase_nxt = RPSS_OUT_HOLD;
          count_nxt = '0;
          pins_nxt.isa_mem_read_n  = 1'b1;
          pins_nxt.isa_mem_write_n = 1'b1;
          pins_nxt.isa_io_read_n   = 1'b1;
          pins_nxt.isa_io_write_n  = 1'b1;
          if (isa_like(strap_r)) begin
            pins_nxt.system_address = SA_HOLD_ADDR;
          end
        end
        RPSS_OUT_HOLD: begin
          if (count_r >= CW'(HOLD_CYCLES - 1)) begin
            phase_nxt  = RPSS_MEM_INIT;
            count_nxt  = '0;
            orst_n_nxt = 1'b1;
            pf_nxt.start    = 1'b1;
            pf_nxt.addr     = BOOT_PREFETCH_ADDR;
            pf_nxt.on_pci   = (strap_r != STRAP_LOCAL);
            pf_nxt.on_isa   = isa_like(strap_r);
            pf_nxt.on_local = (strap_r == STRAP_LOCAL);
            wr_nxt = 1'b1;
          end else begin
            count_nxt = count_r + CW'(1);
          end
        end
        RPSS_MEM_INIT: begin
          // Memory stays closed until the last init write has gone out.
          if (count_r >= CW'(INIT_WRITES - 1)) begin
            phase_nxt = RPSS_RUN;
            wr_nxt    = 1'b0;
            rdy_nxt   = 1'b1;
          end else begin
            count_nxt = count_r + CW'(1);
          end
        end
        RPSS_RUN: begin
          phase_nxt = RPSS_RUN;
        end
        default: begin
          phase_nxt  = RPSS_IN_RST;
          orst_n_nxt = 1'b0;
          pins_nxt   = PINS_RESET;
        end
      endcase
    end
  end

  // State registers; the block reset forces the same picture as input reset, except that the strap loads STRAP_ISA.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      phase_r  <= RPSS_IN_RST;
      count_r  <= '0;
      strap_r  <= STRAP_ISA;
      orst_n_r <= 1'b0;
      pins_r   <= PINS_RESET;
      pf_r     <= '0;
      wr_r     <= 1'b0;
      rdy_r    <= 1'b0;
    end else begin
      phase_r  <= phase_nxt;
      count_r  <= count_nxt;
      strap_r  <= strap_nxt;
      orst_n_r <= orst_n_nxt;
      pins_r   <= pins_nxt;
      pf_r     <= pf_nxt;
      wr_r     <= wr_nxt;
      rdy_r    <= rdy_nxt;
    end
  end

  // Outputs straight from the flops.
  assign system_reset_output_n_o = orst_n_r;
  assign pins_o                  = pins_r;
  assign prefetch_o              = pf_r;
  assign mem_init_write_o        = wr_r;
  assign mem_ready_o             = rdy_r;
  assign strap_latched_o         = strap_r;

  // Checks on the sequence.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_in_rst_seen;
    $past(!system_reset_input_n_i);
  endsequence

  sequence s_release_edge;
    $rose(orst_n_r);
  endsequence

  chk_ide_strobes_high: assert property (s_in_rst_seen |->
      pins_r.ide_primary_read_strobe_n && pins_r.ide_primary_write_strobe_n &&
      pins_r.ide_secondary_read_strobe_n && pins_r.ide_secondary_write_strobe_n)
    else $error("IDE strobe low during input reset");

  chk_flash_sel_high: assert property (s_in_rst_seen |->
      pins_r.flash_bank0_select_n && pins_r.flash_bank1_select_n &&
      pins_r.flash_bank0_low_select_n && pins_r.flash_bank0_high_select_n &&
      pins_r.flash_bank1_low_select_n && pins_r.flash_bank1_high_select_n)
    else $error("Flash select low during input reset");

  chk_card_enables_high: assert property (s_in_rst_seen |->
      pins_r.card_enable1_n && pins_r.card_enable2_n &&
      pins_r.card_5v_supply_enable && pins_r.card_3v_supply_enable)
    else $error("Card enable low during input reset");

  chk_panel_pins_low: assert property (s_in_rst_seen |->
      !pins_r.panel_data_enable && !pins_r.panel_logic_supply_enable &&
      !pins_r.panel_backlight_supply_enable && !pins_r.backlight_pulse_width_out)
    else $error("Panel pin high during input reset");

  chk_isa_hold_addr: assert property ((phase_r == RPSS_OUT_HOLD) && isa_like(strap_r) |->
      pins_r.system_address == SA_HOLD_ADDR && pins_r.isa_io_write_n && pins_r.isa_mem_read_n)
    else $error("ISA hold address or strobe wrong");

  chk_isa_strobes_hold: assert property ((phase_r == RPSS_OUT_HOLD) |->
      pins_r.isa_mem_read_n && pins_r.isa_mem_write_n &&
      pins_r.isa_io_read_n && pins_r.isa_io_write_n && !orst_n_r)
    else $error("ISA strobe low while output reset held");

  chk_prefetch_launch: assert property (s_release_edge |->
      pf_r.start && pf_r.addr == BOOT_PREFETCH_ADDR)
    else $error("Prefetch not launched at release");

  chk_prefetch_on_pci: assert property (pf_r.start |->
      pf_r.on_pci == (strap_r != STRAP_LOCAL))
    else $error("Prefetch bus choice wrong");

  chk_hold_min_time: assert property ($rose(system_reset_input_n_i) ##1 1'b1 |->
      !orst_n_r [*2])
    else $error("Output reset released too early");

  chk_init_before_ready: assert property (s_release_edge |->
      mem_init_write_o && !mem_ready_o ##1 !mem_ready_o)
    else $error("Memory ready before init writes");

  // Once past the first boundary the pin group must not move again until input reset returns.
  chk_pins_frozen_late: assert property ((phase_r != RPSS_IN_RST) &&
      system_reset_input_n_i |=> $stable(pins_r))
    else $error("Pin level moved outside a phase boundary");

  // Input reset must pull output reset and all launch outputs back down on the next edge.
  chk_in_rst_orst_low: assert property (!system_reset_input_n_i |=>
      !orst_n_r && !pf_r.start && !wr_r && !rdy_r)
    else $error("Output reset or launch active during input reset");

  // Ready may only open as the last init write ends, with output reset already gone.
  chk_ready_after_init: assert property ($rose(rdy_r) |->
      !wr_r && $past(wr_r) && orst_n_r)
    else $error("Memory ready without a finished init write run");

  // A prefetch launch outside the release edge would fetch from a bus still in reset.
  chk_start_only_release: assert property (pf_r.start |->
      s_release_edge)
    else $error("Prefetch launched away from the release edge");

endmodule

// ---- tb/rpss_boot_model.sv ----
// Boot memory model: counts init writes and remembers the first fetch address.
// Assumes the sequencer outputs are registered on clk_i.
`timescale 1ns/1ps

module rpss_boot_model (
  // Clock and sequenced reset.
  input  wire logic                     clk_i,
  input  wire logic                     system_reset_output_n_i,
  // Sequencer requests.
  input  wire rpss_pkg::rpss_prefetch_t prefetch_i,
  input  wire logic                     mem_init_write_i,
  input  wire logic                     mem_ready_i,
  // What the memory saw.
  output int unsigned                   init_count_o,
  output logic [23:0]                   fetch_addr_o,
  output logic                          early_access_o
);
  import rpss_pkg::*;

  // Memory refuses service until it has been written once; a real part would hang.
  always_ff @(posedge clk_i) begin
    if (!system_reset_output_n_i) begin
      init_count_o   <= 0;
      early_access_o <= 1'b0;
    end else begin
      if (mem_init_write_i) init_count_o <= init_count_o + 1;
      if (mem_ready_i && init_count_o == 0) early_access_o <= 1'b1;
      if (prefetch_i.start) fetch_addr_o <= prefetch_i.addr;
    end
  end
endmodule

// ---- tb/reset_pin_state_sequencer_tb.sv ----
// Self-checking bench for the reset pin-state sequencer with a boot memory model.
// Assumes shortened hold and init counts.
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin $display("BAD t=%0t got=%h exp=%h", $time, g, e); err_total++; end end

module reset_pin_state_sequencer_tb;
  import rpss_pkg::*;
  localparam int unsigned HOLD = 4;
  localparam int unsigned INIT = 2;
  logic           clk_i    = 1'b0;
  logic           resetn_i = 1'b0;
  logic           sys_in_n = 1'b0;
  logic [1:0]     strap    = 2'h0;
  logic           out_n;
  rpss_pins_t     pins;
  rpss_prefetch_t pf;
  logic           init_w;
  logic           ready;
  logic [1:0]     latched;
  int unsigned    m_count;
  logic [23:0]    m_addr;
  logic           m_early;
  int             err_total  = 0;
  int             num_checks = 0;

  // Free-running 100 MHz clock.
  always #5 clk_i = ~clk_i;

  rpss_sequencer #(.HOLD_CYCLES(HOLD), .INIT_WRITES(INIT)) dut (
    .clk_i(clk_i), .resetn_i(resetn_i), .system_reset_input_n_i(sys_in_n),
    .strap_mode_i(strap), .system_reset_output_n_o(out_n), .pins_o(pins),
    .prefetch_o(pf), .mem_init_write_o(init_w), .mem_ready_o(ready),
    .strap_latched_o(latched));

  rpss_boot_model mem (
    .clk_i(clk_i), .system_reset_output_n_i(out_n), .prefetch_i(pf),
    .mem_init_write_i(init_w), .mem_ready_i(ready), .init_count_o(m_count),
    .fetch_addr_o(m_addr), .early_access_o(m_early));

  // Prints the verdict and stops the run.
  task automatic conclude();
    if (err_total == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Holds input reset and checks the reset pin group; the low address byte is free.
  task automatic enter_reset(input logic [1:0] s);
    rpss_pins_t got;
    @(posedge clk_i) sys_in_n <= 1'b0;
    strap <= s;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    got = pins;
    got.system_address[7:0] = PINS_RESET.system_address[7:0];
    `CHK(got, PINS_RESET)
    `CHK(pins.system_address[19:8], 12'hfff)
    `CHK(out_n, 1'b0)
  endtask

  // Releases input reset, follows the hold and the init writes for one strap.
  task automatic run_boot(input logic [1:0] s);
    rpss_pins_t held;
    int n;
    logic isa;
    isa = (s == STRAP_ISA) || (s == STRAP_PCMCIA);
    enter_reset(s);
    @(posedge clk_i) sys_in_n <= 1'b1;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    held = pins;
    `CHK({pins.isa_mem_read_n, pins.isa_mem_write_n, pins.isa_io_read_n, pins.isa_io_write_n}, 4'hf)
    if (isa) `CHK(pins.system_address, SA_HOLD_ADDR)
    // A strap move after release must not reach the fetch routing.
    @(posedge clk_i) strap <= ~s;
    @(negedge clk_i);
    for (n = 1; n < 50 && out_n !== 1'b1; n++) begin
      `CHK(pins, held)
      `CHK(pf.start, 1'b0)
      @(negedge clk_i);
    end
    if (n >= 50) begin
      err_total++;
      conclude();
    end
    `CHK(n, HOLD - 1)
    `CHK(pf.start, 1'b1)
    `CHK(pf.addr, BOOT_PREFETCH_ADDR)
    `CHK(pf.on_pci, s != STRAP_LOCAL)
    `CHK(pf.on_isa, isa)
    `CHK(pf.on_local, s == STRAP_LOCAL)
    for (n = 0; n < INIT; n++) begin
      `CHK({init_w, ready}, 2'h2)
      @(negedge clk_i);
    end
    `CHK({init_w, ready, pf.start}, 3'h2)
    `CHK(latched, s)
    `CHK(m_count, INIT)
    `CHK(m_addr, BOOT_PREFETCH_ADDR)
    `CHK(m_early, 1'b0)
  endtask

  // Input reset returning during the hold must restart everything.
  task automatic abort_hold();
    enter_reset(STRAP_PCMCIA);
    @(posedge clk_i) sys_in_n <= 1'b1;
    repeat (3) @(posedge clk_i);
    sys_in_n <= 1'b0;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    `CHK({out_n, pf.start, init_w, ready}, 4'h0)
    `CHK(pins.ide_primary_read_strobe_n, 1'b1)
    run_boot(STRAP_PCMCIA);
  endtask

  // Main sequence: block reset, every strap code, then an aborted hold.
  initial begin
    repeat (3) @(posedge clk_i);
    resetn_i <= 1'b1;
    for (int s = 0; s < 4; s++) run_boot(s[1:0]);
    abort_hold();
    conclude();
  end
endmodule
